/* File: test/testbench.sv */
// Purpose: Self-checking bench for the conversion sequencer
// Assumes: Tick divider shortened to 4 cycles; one conversion is 124 cycles
// Notes:   Durations are checked with a few cycles of slack for tick alignment

`timescale 1ns/1ns

module testbench;
	import tsq_pkg::*;

	localparam int DIV  = 4;
	localparam int CONV = 31 * DIV;
	localparam logic [15:0] CODES [4] = '{16'h0080, 16'h8000, 16'h7FFF, 16'hF380};
	localparam int SIZES [4] = '{1, 8, 32, 64};

	logic        clock = 1'h0;
	logic        srst = 1'h1;
	logic [1:0]  startup_mode_sel = 2'h3;
	logic [15:0] adc_value = 16'h0000;
	logic [2:0]  pin_mode = 3'h0;
	logic        cfg_write, cfg_read, result_read, upper_write, lower_write;
	logic [1:0]  conversion_mode_sel, average_count_sel;
	logic [2:0]  cycle_time_sel;
	logic        ready_to_pin_enable, window_or_hysteresis_sel, alert_pin_polarity;
	logic [15:0] threshold_data, temp_result, upper_threshold, lower_threshold;
	logic        converter_on, data_ready, high_alert, low_alert, alert_pin;
	logic        power_down_state, single_conversion_state;
	int          errors = 0;
	int          tests_run = 0;

	always #5 clock = ~clock;

	// ****************************************
	// Design and host
	// ****************************************
	tsq_sequencer #(.TICK_DIV(DIV)) DUT (.clock, .srst, .startup_mode_sel, .cfg_write,
		.conversion_mode_sel, .average_count_sel, .cycle_time_sel, .ready_to_pin_enable,
		.window_or_hysteresis_sel, .alert_pin_polarity, .cfg_read, .result_read,
		.upper_write, .lower_write, .threshold_data, .adc_value, .converter_on,
		.temp_result, .upper_threshold, .lower_threshold, .data_ready, .high_alert,
		.low_alert, .power_down_state, .single_conversion_state, .alert_pin);

	tsq_host host (.clock, .cfg_write, .conversion_mode_sel, .average_count_sel,
		.cycle_time_sel, .ready_to_pin_enable, .window_or_hysteresis_sel,
		.alert_pin_polarity, .cfg_read, .result_read, .upper_write, .lower_write,
		.threshold_data);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic int now();
		return int'($time / 10);
	endfunction

	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic set_adc(input logic [15:0] v);
		@(posedge clock);
		adc_value <= v;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask

	task automatic near(input string n, input int e, input int g, input int tol);
		tests_run++;
		if (g < e - tol || g > e + tol) begin
			errors++;
			$display("unexpected %s: expected %0d, seen %0d", n, e, g);
		end
	endtask

	// Bounded so a lost completion cannot hang the run
	task automatic wait_ready(output int t);
		int k;
		// Callers may return on the edge that clears the flag, before it settles
		#1;
		k = 0;
		while (data_ready !== 1'h1 && k < 20000) begin
			step(1);
			k++;
		end
		chk("ready seen", 16'h0001, data_ready);
		t = now();
	endtask

	// Clears a stale ready first so the wait sees only the new result
	task automatic shot(input logic [15:0] v, input logic [1:0] a, output int d);
		int t1;
		int t0;
		host.rd(1'h1);
		set_adc(v);
		host.cfg(MODE_ONESHOT, a, 3'h7, pin_mode);
		t1 = now();
		wait_ready(t0);
		d = t0 - t1;
	endtask

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clock);
		errors++;
		give_verdict;
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		int d;
		int t0;
		int t1;
		repeat (5) @(posedge clock);
		srst <= 1'h0;
		step(2);
		chk("reset result", 16'h8000, temp_result);
		chk("reset upper", 16'h7FFF, upper_threshold);
		chk("reset lower", 16'h8000, lower_threshold);
		chk("reset pin", 16'h0001, alert_pin);
		chk("strap shutdown", 16'h0001, power_down_state);
		chk("strap idle", 16'h0000, converter_on);
		for (int i = 0; i < 4; i++) begin
			shot(CODES[i], 2'(i), d);
			near("group length", SIZES[i] * CONV, d, 6);
			chk("result code", CODES[i], temp_result);
		end
		chk("back to shutdown", 16'h0001, power_down_state);
		host.rd(1'h0);
		step(2);
		chk("ready cleared", 16'h0000, data_ready);
		set_adc(16'hFFF0);
		host.cfg(MODE_ONESHOT, AVG_EIGHT, 3'h0, 3'h0);
		step(4 * CONV + 60);
		chk("one-shot busy", 16'h0001, single_conversion_state);
		set_adc(16'h0001);
		wait_ready(t0);
		chk("group mean", 16'hFFF8, temp_result);
		host.lim(1'h1, 16'h0100);
		host.lim(1'h0, 16'h0000);
		step(2);
		chk("upper written", 16'h0100, upper_threshold);
		chk("lower written", 16'h0000, lower_threshold);
		shot(16'h0200, AVG_NONE, d);
		chk("high set", 16'h0002, {high_alert, low_alert});
		chk("pin active low", 16'h0000, alert_pin);
		host.rd(1'h0);
		step(2);
		chk("high cleared", 16'h0000, high_alert);
		chk("pin released", 16'h0001, alert_pin);
		shot(16'h0100, AVG_NONE, d);
		chk("at limit", 16'h0000, high_alert);
		shot(16'hFF00, AVG_NONE, d);
		chk("low set", 16'h0001, {high_alert, low_alert});
		pin_mode = 3'h3;
		shot(16'h0200, AVG_NONE, d);
		chk("hyst high", 16'h0002, {high_alert, low_alert});
		chk("pin active high", 16'h0001, alert_pin);
		host.rd(1'h0);
		step(2);
		chk("read ignored", 16'h0001, high_alert);
		shot(16'h0080, AVG_NONE, d);
		chk("hyst hold", 16'h0001, high_alert);
		shot(16'hFF00, AVG_NONE, d);
		chk("hyst clear", 16'h0000, {high_alert, low_alert, alert_pin});
		pin_mode = 3'h5;
		shot(16'h0000, AVG_NONE, d);
		chk("ready on pin", 16'h0001, alert_pin);
		host.rd(1'h0);
		step(2);
		chk("ready off pin", 16'h0000, {data_ready, alert_pin});
		host.cfg(MODE_CONT_A, AVG_NONE, 3'h1, 3'h0);
		wait_ready(t0);
		host.rd(1'h1);
		wait_ready(t1);
		near("cycle period", 250 * DIV, t1 - t0, 3);
		host.cfg(MODE_CONT_B, AVG_NONE, 3'h1, 3'h0);
		step(20);
		chk("converting", 16'h0001, converter_on);
		host.cfg(MODE_SHUTDOWN, AVG_NONE, 3'h1, 3'h0);
		step(1);
		chk("aborted", 16'h0001, {converter_on, power_down_state});
		host.rd(1'h1);
		step(300);
		chk("no result", 16'h0000, data_ready);
		@(posedge clock);
		srst <= 1'h1;
		startup_mode_sel <= 2'h0;
		adc_value <= 16'h0C80;
		repeat (5) @(posedge clock);
		srst <= 1'h0;
		step(2);
		chk("second reset result", 16'h8000, temp_result);
		t1 = now();
		wait_ready(t0);
		near("default group", 8 * CONV, t0 - t1, 6);
		chk("default result", 16'h0C80, temp_result);
		host.rd(1'h1);
		wait_ready(t1);
		near("default cycle", 2000 * DIV, t1 - t0, 3);
		give_verdict;
	end
endmodule

/* File: test/tsq_host.sv */
// Purpose: Host model issuing register accesses to the sequencer
// Assumes: Strobes move just after a rising edge
// Notes:   One access per call; each strobe is high for one cycle

`timescale 1ns/1ns

module tsq_host (
	input  wire logic   clock,                    // Clock
	output logic        cfg_write,                // Config write
	output logic [1:0]  conversion_mode_sel,      // Mode
	output logic [1:0]  average_count_sel,        // Averaging
	output logic [2:0]  cycle_time_sel,           // Cycle time
	output logic        ready_to_pin_enable,      // Ready routing
	output logic        window_or_hysteresis_sel, // Alert mode
	output logic        alert_pin_polarity,       // Pin polarity
	output logic        cfg_read,                 // Config read
	output logic        result_read,              // Result read
	output logic        upper_write,              // Upper limit write
	output logic        lower_write,              // Lower limit write
	output logic [15:0] threshold_data            // Limit data
);
	initial begin
		{cfg_write, cfg_read, result_read, upper_write, lower_write} = 5'h00;
		{conversion_mode_sel, average_count_sel, cycle_time_sel} = 7'h00;
		{ready_to_pin_enable, window_or_hysteresis_sel, alert_pin_polarity} = 3'h0;
		threshold_data = 16'h0000;
	end

	// Fields stay put after the strobe, as a real register would
	task automatic cfg(input logic [1:0] m, input logic [1:0] a, input logic [2:0] c,
		input logic [2:0] rhp);
		@(posedge clock);
		cfg_write <= 1'h1;
		{conversion_mode_sel, average_count_sel, cycle_time_sel} <= {m, a, c};
		{ready_to_pin_enable, window_or_hysteresis_sel, alert_pin_polarity} <= rhp;
		@(posedge clock);
		cfg_write <= 1'h0;
	endtask

	task automatic rd(input logic res);
		@(posedge clock);
		result_read <= res;
		cfg_read <= !res;
		@(posedge clock);
		result_read <= 1'h0;
		cfg_read <= 1'h0;
	endtask

	// Limits are handed over already in result encoding
	task automatic lim(input logic up, input logic [15:0] d);
		@(posedge clock);
		upper_write <= up;
		lower_write <= !up;
		threshold_data <= d;
		@(posedge clock);
		{upper_write, lower_write} <= 2'h0;
	endtask
endmodule

/* File: verilog/tsq_avg.sv */
// Purpose: Accumulates a conversion group and publishes its mean
// Assumes: Group size is a power of two given as a shift
// Notes:   Arithmetic shift truncates toward minus infinity

`timescale 1ns/1ns

module tsq_avg
	import tsq_pkg::*;
#(
	parameter int LOG2_MAX = AVG_LOG2_MAX
) (
	input  wire logic        clock,        // System clock
	input  wire logic        srst,         // Synchronous reset
	input  wire logic        clear,        // Drop a partial group
	input  wire logic        sample_valid, // One conversion done
	input  wire logic        sample_last,  // Last of the group
	input  wire logic [15:0] sample,       // Conversion value
	input  wire logic [2:0]  shift,        // log2 of group size
	output logic             mean_valid,   // One-cycle publish pulse
	output logic [15:0]      mean          // Group mean
);

	localparam int ACC_W = 16 + LOG2_MAX;

	logic signed [ACC_W-1:0] acc_reg;
	logic signed [ACC_W-1:0] acc_next;
	logic signed [ACC_W-1:0] sum;
	logic signed [ACC_W-1:0] quot;
	logic [15:0]             mean_reg;
	logic [15:0]             mean_next;
	logic                    valid_reg;
	logic                    valid_next;

	always_comb begin
		sum        = acc_reg + ACC_W'(signed'(sample));
		quot       = sum >>> shift;
		acc_next   = acc_reg;
		mean_next  = mean_reg;
		valid_next = 1'b0;
		if (clear) begin
			acc_next = '0;
		end else if (sample_valid) begin
			if (sample_last) begin
				acc_next   = '0;
				mean_next  = quot[15:0];
				valid_next = 1'b1;
			end else begin
				acc_next = sum;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			acc_reg   <= '0;
			mean_reg  <= '0;
			valid_reg <= 1'b0;
		end else begin
			acc_reg   <= acc_next;
			mean_reg  <= mean_next;
			valid_reg <= valid_next;
		end
	end

	assign mean       = mean_reg;
	assign mean_valid = valid_reg;

	a_single_pass : assert property (@(posedge clock) disable iff (srst)
		sample_valid && sample_last && !clear && shift == 3'h0 && acc_reg == '0
		|=> mean_reg == $past(sample))
		else $error("single conversion not passed through");

endmodule

/* File: verilog/tsq_pkg.sv */
// Purpose: Shared constants for the temperature conversion sequencer
// Assumes: 100 MHz clock; timing is kept in half-millisecond ticks
// Notes:   Cycle-time table values are plain defaults

package tsq_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ         = 100;
	localparam int TICK_US         = 500;
	localparam int TICK_CYCLES     = TICK_US * CLK_MHZ;
	localparam int CONV_TIME_US    = 15500;
	localparam int CONV_TICKS_INT  = CONV_TIME_US / TICK_US;
	localparam int TICK_CNT_W      = 20;
	localparam int CYC_CNT_W       = 16;
	localparam logic [7:0] CONV_TICKS = CONV_TICKS_INT[7:0];

	// Conversion cycle length, active plus standby, per cycle-time code, in ticks (1 s = 2000)
	localparam logic [CYC_CNT_W-1:0] CYCLE_TICKS [8] = '{
		16'h001F, 16'h00FA, 16'h01F4, 16'h03E8,
		16'h07D0, 16'h1F40, 16'h3E80, 16'h7D00
	};

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [1:0] MODE_CONT_A   = 2'h0;
	localparam logic [1:0] MODE_SHUTDOWN = 2'h1;
	localparam logic [1:0] MODE_CONT_B   = 2'h2;
	localparam logic [1:0] MODE_ONESHOT  = 2'h3;
	localparam logic [1:0] AVG_NONE      = 2'h0;
	localparam logic [1:0] AVG_EIGHT     = 2'h1;
	localparam logic [2:0] CYCLE_1S      = 3'h4;

	// Group sizes as log2 per averaging code
	localparam logic [2:0] AVG_LOG2 [4] = '{3'h0, 3'h3, 3'h5, 3'h6};
	localparam int AVG_LOG2_MAX = 6;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [15:0] RESULT_RESET = 16'h8000;
	localparam logic [15:0] UPPER_RESET  = 16'h7FFF;
	localparam logic [15:0] LOWER_RESET  = 16'h8000;

endpackage

/* File: verilog/tsq_sequencer.sv */
// Purpose: Conversion sequencer of a digital temperature sensor
// Assumes: Register reads and writes arrive as same-clock strobes
// Notes:   Converter output is sampled at the end of each conversion

`timescale 1ns/1ns

module tsq_sequencer
	import tsq_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input  wire logic        clock,                    // 100 MHz clock
	input  wire logic        srst,                     // Synchronous reset
	input  wire logic [1:0]  startup_mode_sel,         // Stored start-up mode
	input  wire logic        cfg_write,                // Configuration write strobe
	input  wire logic [1:0]  conversion_mode_sel,      // Mode field
	input  wire logic [1:0]  average_count_sel,        // Averaging field
	input  wire logic [2:0]  cycle_time_sel,           // Cycle-time field
	input  wire logic        ready_to_pin_enable,      // Ready flag onto pin
	input  wire logic        window_or_hysteresis_sel, // 1 selects hysteresis
	input  wire logic        alert_pin_polarity,       // 1 = pin active high
	input  wire logic        cfg_read,                 // Configuration read strobe
	input  wire logic        result_read,              // Result read strobe
	input  wire logic        upper_write,              // Upper limit write
	input  wire logic        lower_write,              // Lower limit write
	input  wire logic [15:0] threshold_data,           // Limit write data
	input  wire logic [15:0] adc_value,                // Converter output
	output logic             converter_on,             // Active circuitry on
	output logic [15:0]      temp_result,              // Result register
	output logic [15:0]      upper_threshold,          // Upper limit register
	output logic [15:0]      lower_threshold,          // Lower limit register
	output logic             data_ready,               // Data-ready flag
	output logic             high_alert,               // High alert flag
	output logic             low_alert,                // Low alert flag
	output logic             power_down_state,         // In shutdown
	output logic             single_conversion_state,  // One-shot running
	output logic             alert_pin                 // Alert pin level
);

	typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_ACTIVE, ST_STANDBY} tsq_state_t;

	// ****************************************
	// State
	// ****************************************
	tsq_state_t       state_reg, state_next;
	logic [1:0]       mode_reg, mode_next;
	logic [1:0]       avg_reg, avg_next;
	logic [2:0]       cyc_sel_reg, cyc_sel_next;
	logic             dr_pin_reg, dr_pin_next;
	logic             hyst_reg, hyst_next;
	logic             pol_reg, pol_next;
	logic [15:0]      upper_reg, upper_next;
	logic [15:0]      lower_reg, lower_next;
	logic [15:0]      result_reg, result_next;
	logic             ready_reg, ready_next;
	logic             high_reg, high_next;
	logic             low_reg, low_next;
	logic             pin_reg, pin_next;
	logic [7:0]       conv_cnt_reg, conv_cnt_next;
	logic [6:0]       sample_cnt_reg, sample_cnt_next;
	logic [CYC_CNT_W-1:0] cyc_cnt_reg, cyc_cnt_next;

	logic             tick;
	logic             restart;
	logic             smp_valid;
	logic             smp_last;
	logic             abort;
	logic             avg_valid;
	logic [15:0]      avg_mean;
	logic [6:0]       group_size;
	logic             oneshot;
	logic             start_run;

	tsq_tick #(
		.DIV     (TICK_DIV)
	) u_tick (
		.clock   (clock),
		.srst    (srst),
		.restart (restart),
		.tick    (tick)
	);

	tsq_avg u_avg (
		.clock        (clock),
		.srst         (srst),
		.clear        (abort),
		.sample_valid (smp_valid),
		.sample_last  (smp_last),
		.sample       (adc_value),
		.shift        (AVG_LOG2[avg_reg]),
		.mean_valid   (avg_valid),
		.mean         (avg_mean)
	);

	// ****************************************
	// Conversion scheduling
	// ****************************************
	always_comb begin
		state_next      = state_reg;
		mode_next       = mode_reg;
		avg_next        = avg_reg;
		cyc_sel_next    = cyc_sel_reg;
		dr_pin_next     = dr_pin_reg;
		hyst_next       = hyst_reg;
		pol_next        = pol_reg;
		conv_cnt_next   = conv_cnt_reg;
		sample_cnt_next = sample_cnt_reg;
		cyc_cnt_next    = cyc_cnt_reg;
		group_size      = 7'(1) << AVG_LOG2[avg_reg];
		oneshot         = (mode_reg == MODE_ONESHOT);
		smp_valid       = 1'b0;
		smp_last        = 1'b0;
		abort           = 1'b0;
		start_run       = 1'b0;
		if (tick && state_reg != ST_BOOT) begin
			cyc_cnt_next = cyc_cnt_reg + 1'b1;
		end
		case (state_reg)
			ST_BOOT: begin
				// Strap is caught one edge after reset, never under reset
				if (startup_mode_sel == MODE_ONESHOT) begin
					mode_next  = MODE_SHUTDOWN;
					state_next = ST_IDLE;
				end else begin
					mode_next  = startup_mode_sel;
					state_next = (startup_mode_sel == MODE_SHUTDOWN) ? ST_IDLE : ST_ACTIVE;
					start_run  = (startup_mode_sel != MODE_SHUTDOWN);
				end
			end
			ST_ACTIVE: begin
				if (tick) begin
					conv_cnt_next = conv_cnt_reg + 1'b1;
					if (conv_cnt_reg == CONV_TICKS - 8'h01) begin
						conv_cnt_next   = '0;
						smp_valid       = 1'b1;
						sample_cnt_next = sample_cnt_reg + 1'b1;
						if (sample_cnt_reg == group_size - 7'h01) begin
							smp_last        = 1'b1;
							sample_cnt_next = '0;
							if (oneshot) begin
								mode_next  = MODE_SHUTDOWN;
								state_next = ST_IDLE;
							end else begin
								state_next = ST_STANDBY;
							end
						end
					end
				end
			end
			ST_STANDBY: begin
				// An active period longer than the cycle starts the next one at once
				if (cyc_cnt_next >= CYCLE_TICKS[cyc_sel_reg]) begin
					state_next = ST_ACTIVE;
					start_run  = 1'b1;
				end
			end
			ST_IDLE: begin
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (cfg_write && state_reg != ST_BOOT) begin
			mode_next    = conversion_mode_sel;
			avg_next     = average_count_sel;
			cyc_sel_next = cycle_time_sel;
			dr_pin_next  = ready_to_pin_enable;
			hyst_next    = window_or_hysteresis_sel;
			pol_next     = alert_pin_polarity;
			abort        = 1'b1;
			smp_valid    = 1'b0;
			if (conversion_mode_sel == MODE_SHUTDOWN) begin
				state_next = ST_IDLE;
			end else begin
				state_next = ST_ACTIVE;
				start_run  = 1'b1;
			end
		end
		if (start_run) begin
			conv_cnt_next   = '0;
			sample_cnt_next = '0;
			cyc_cnt_next    = '0;
		end
	end

	assign restart = start_run;

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg      <= ST_BOOT;
			mode_reg       <= MODE_SHUTDOWN;
			avg_reg        <= AVG_EIGHT;
			cyc_sel_reg    <= CYCLE_1S;
			dr_pin_reg     <= 1'b0;
			hyst_reg       <= 1'b0;
			pol_reg        <= 1'b0;
			conv_cnt_reg   <= '0;
			sample_cnt_reg <= '0;
			cyc_cnt_reg    <= '0;
		end else begin
			state_reg      <= state_next;
			mode_reg       <= mode_next;
			avg_reg        <= avg_next;
			cyc_sel_reg    <= cyc_sel_next;
			dr_pin_reg     <= dr_pin_next;
			hyst_reg       <= hyst_next;
			pol_reg        <= pol_next;
			conv_cnt_reg   <= conv_cnt_next;
			sample_cnt_reg <= sample_cnt_next;
			cyc_cnt_reg    <= cyc_cnt_next;
		end
	end

	// ****************************************
	// Result, limits and flags
	// ****************************************
	always_comb begin
		upper_next  = upper_write ? threshold_data : upper_reg;
		lower_next  = lower_write ? threshold_data : lower_reg;
		result_next = result_reg;
		ready_next  = ready_reg;
		high_next   = high_reg;
		low_next    = low_reg;
		// Reads clear first so a completion in the same cycle wins
		if (cfg_read || result_read) begin
			ready_next = 1'b0;
		end
		if (cfg_read && !hyst_reg) begin
			high_next = 1'b0;
			low_next  = 1'b0;
		end
		if (avg_valid) begin
			result_next = avg_mean;
			ready_next  = 1'b1;
			if (hyst_reg) begin
				if ($signed(avg_mean) > $signed(upper_reg)) begin
					high_next = 1'b1;
				end else if ($signed(avg_mean) < $signed(lower_reg)) begin
					high_next = 1'b0;
				end
			end else begin
				if ($signed(avg_mean) > $signed(upper_reg)) begin
					high_next = 1'b1;
				end
				if ($signed(avg_mean) < $signed(lower_reg)) begin
					low_next = 1'b1;
				end
			end
		end
		if (hyst_reg) begin
			low_next = 1'b0;
		end
		pin_next = (dr_pin_reg ? ready_next : (high_next | low_next))
			~^ pol_reg;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			upper_reg  <= UPPER_RESET;
			lower_reg  <= LOWER_RESET;
			result_reg <= RESULT_RESET;
			ready_reg  <= 1'b0;
			high_reg   <= 1'b0;
			low_reg    <= 1'b0;
			pin_reg    <= 1'b1;
		end else begin
			upper_reg  <= upper_next;
			lower_reg  <= lower_next;
			result_reg <= result_next;
			ready_reg  <= ready_next;
			high_reg   <= high_next;
			low_reg    <= low_next;
			pin_reg    <= pin_next;
		end
	end

	assign converter_on            = (state_reg == ST_ACTIVE);
	assign power_down_state        = (state_reg == ST_IDLE);
	assign single_conversion_state = (state_reg == ST_ACTIVE) && oneshot;
	assign temp_result             = result_reg;
	assign upper_threshold         = upper_reg;
	assign lower_threshold         = lower_reg;
	assign data_ready              = ready_reg;
	assign high_alert              = high_reg;
	assign low_alert               = low_reg;
	assign alert_pin               = pin_reg;

	// ****************************************
	// Checks
	// ****************************************
	a_result_reset : assert property (@(posedge clock)
		$fell(srst) |-> result_reg == RESULT_RESET)
		else $error("result not at reset code after reset");

	a_result_update : assert property (@(posedge clock) disable iff (srst)
		avg_valid |=> result_reg == $past(avg_mean))
		else $error("result not updated on completion");

	a_ready_set : assert property (@(posedge clock) disable iff (srst)
		avg_valid |=> ready_reg)
		else $error("ready flag not set on completion");

	a_ready_clear : assert property (@(posedge clock) disable iff (srst)
		(cfg_read || result_read) && !avg_valid |=> !ready_reg)
		else $error("ready flag survived a read");

	a_shutdown_abort : assert property (@(posedge clock) disable iff (srst)
		cfg_write && state_reg != ST_BOOT && conversion_mode_sel == MODE_SHUTDOWN
		|=> state_reg == ST_IDLE ##1 !avg_valid)
		else $error("shutdown write did not abort");

	a_oneshot_end : assert property (@(posedge clock) disable iff (srst)
		smp_last && oneshot && !cfg_write |=> state_reg == ST_IDLE ##1 ready_reg)
		else $error("one-shot did not end in shutdown");

	a_hyst_low_zero : assert property (@(posedge clock) disable iff (srst)
		hyst_reg |=> !low_reg)
		else $error("low flag set in hysteresis mode");

	a_pin_route : assert property (@(posedge clock) disable iff (srst)
		##1 pin_reg == (($past(dr_pin_reg) ? ready_reg : (high_reg | low_reg))
		~^ $past(pol_reg)))
		else $error("alert pin does not follow its source");

	a_conv_period : assert property (@(posedge clock) disable iff (srst)
		smp_valid |-> conv_cnt_reg == CONV_TICKS - 8'h01 && tick)
		else $error("conversion ended at wrong time");

endmodule

/* File: verilog/tsq_tick.sv */
// Purpose: Half-millisecond tick divider, restartable
// Assumes: One clock; tick is a one-cycle enable
// Notes:   Restart aligns the first tick to a cycle start

`timescale 1ns/1ns

module tsq_tick
	import tsq_pkg::*;
#(
	parameter int DIV = TICK_CYCLES
) (
	input  wire logic clock,   // System clock
	input  wire logic srst,    // Synchronous reset
	input  wire logic restart, // Restart the divider
	output logic      tick     // One-cycle tick pulse
);

	logic [TICK_CNT_W-1:0] cnt_reg;
	logic [TICK_CNT_W-1:0] cnt_next;
	logic                  tick_reg;
	logic                  tick_next;

	localparam logic [TICK_CNT_W-1:0] LAST = TICK_CNT_W'(DIV - 1);

	always_comb begin
		cnt_next  = cnt_reg + 1'b1;
		tick_next = 1'b0;
		if (restart) begin
			cnt_next = '0;
		end else if (cnt_reg == LAST) begin
			cnt_next  = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

	a_tick_single : assert property (@(posedge clock) disable iff (srst)
		tick_reg && DIV > 1 |=> !tick_reg)
		else $error("tick lasted more than one cycle");

endmodule
